/* File: design/tsgpio_regs.vh */
// Register offsets, field positions and reset values of the timestamp-capable pin port.
// Assumes a plain register port with word indices and 32-bit data.
//
// Function
// - Timestamp pins as inputs trigger timestamp capture.
// - Timing-mode outputs follow internal timing logic.
// - Timestamp pins also usable as plain pins.
// - Inputs may select weak pull-up or pull-down.
// - Timestamp pins reset to input, pull-up.
// - Ten plain pins, each input or output.
// - Input pins can raise processor interrupts.
// - Plain pins reset to input, pull-up.
`ifndef TSGPIO_REGS_VH
`define TSGPIO_REGS_VH
`define TSGPIO_ADDR_DIR 4'h0
`define TSGPIO_ADDR_OUT 4'h1
`define TSGPIO_ADDR_IN 4'h2
`define TSGPIO_ADDR_PULL_EN 4'h3
`define TSGPIO_ADDR_PULL_UP 4'h4
`define TSGPIO_ADDR_IRQ_MASK 4'h5
`define TSGPIO_ADDR_IRQ_STAT 4'h6
`define TSGPIO_ADDR_TS_MODE 4'h7
`define TSGPIO_ADDR_TS_EDGE 4'h8
`define TSGPIO_ADDR_TS_CAP 4'h9
`define TSGPIO_TS_LSB 0
`define TSGPIO_GP_LSB 6
`define TSGPIO_RST_DIR 16'h0000
`define TSGPIO_RST_OUT 16'h0000
`define TSGPIO_RST_PULL_EN 16'hffff
`define TSGPIO_RST_PULL_UP 16'hffff
`define TSGPIO_RST_ZERO 16'h0000
`endif

/* File: design/tsgpio_port.v */
// Timestamp-capable pin port: six timing pins in bits 5..0, ten plain pins in bits 15..6.
// Assumes the pad ring resolves pins from out, oe_n and pull controls, pins are asynchronous,
// and the timing logic supplies a free running timestamp on the same clock.
//
// Our own choices: strobed register access and the register offsets.
`include "tsgpio_regs.vh"
`default_nettype none
module tsgpio_port #(
  parameter TS_PINS = 6,
  parameter GP_PINS = 10,
  parameter TS_WIDTH = 32
) (
  input wire clk,
  input wire reset,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire [TS_PINS+GP_PINS-1:0] pin_in,
  output reg [TS_PINS+GP_PINS-1:0] pin_out,
  output reg [TS_PINS+GP_PINS-1:0] pin_oe_n,
  output reg [TS_PINS+GP_PINS-1:0] pin_pull_en,
  output reg [TS_PINS+GP_PINS-1:0] pin_pull_up,
  input wire [TS_PINS-1:0] timing_drive,
  input wire [TS_WIDTH-1:0] timestamp_now,
  output reg [TS_PINS-1:0] ts_capture_pulse,
  output reg [TS_WIDTH-1:0] ts_capture_value,
  output reg irq
);
  localparam N = TS_PINS + GP_PINS;
  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  reg [N-1:0] dir_reg;
  reg [N-1:0] out_reg;
  reg [N-1:0] pull_en_reg;
  reg [N-1:0] pull_up_reg;
  reg [N-1:0] irq_mask_reg;
  reg [N-1:0] irq_stat_reg;
  reg [TS_PINS-1:0] ts_mode_reg;
  reg [TS_PINS-1:0] ts_edge_reg;
  reg [N-1:0] sync1_reg;
  reg [N-1:0] sync2_reg;
  reg [N-1:0] prev_reg;
  reg [TS_WIDTH-1:0] cap_reg;
  reg [N-1:0] irq_stat_next;
  reg [TS_PINS-1:0] cap_hit;
  wire wr_dir = reg_wr && (reg_addr == `TSGPIO_ADDR_DIR);
  wire wr_out = reg_wr && (reg_addr == `TSGPIO_ADDR_OUT);
  wire wr_pen = reg_wr && (reg_addr == `TSGPIO_ADDR_PULL_EN);
  wire wr_pup = reg_wr && (reg_addr == `TSGPIO_ADDR_PULL_UP);
  wire wr_msk = reg_wr && (reg_addr == `TSGPIO_ADDR_IRQ_MASK);
  wire wr_tsm = reg_wr && (reg_addr == `TSGPIO_ADDR_TS_MODE);
  wire wr_tse = reg_wr && (reg_addr == `TSGPIO_ADDR_TS_EDGE);
  wire rd_stat = reg_rd && (reg_addr == `TSGPIO_ADDR_IRQ_STAT);
  wire [N-1:0] in_edge = (sync2_reg ^ prev_reg) & ~dir_reg;
  always @(posedge clk)
  begin
    if (reset)
    begin
      dir_reg <= `TSGPIO_RST_DIR;
      out_reg <= `TSGPIO_RST_OUT;
      pull_en_reg <= `TSGPIO_RST_PULL_EN;
      pull_up_reg <= `TSGPIO_RST_PULL_UP;
      irq_mask_reg <= `TSGPIO_RST_ZERO;
      ts_mode_reg <= {TS_PINS{1'b0}};
      ts_edge_reg <= {TS_PINS{1'b0}};
    end
    else
    begin
      if (wr_dir)
        dir_reg <= reg_wdata[N-1:0];
      if (wr_out)
        out_reg <= reg_wdata[N-1:0];
      if (wr_pen)
        pull_en_reg <= reg_wdata[N-1:0];
      if (wr_pup)
        pull_up_reg <= reg_wdata[N-1:0];
      if (wr_msk)
        irq_mask_reg <= reg_wdata[N-1:0];
      if (wr_tsm)
        ts_mode_reg <= reg_wdata[TS_PINS-1:0];
      if (wr_tse)
        ts_edge_reg <= reg_wdata[TS_PINS-1:0];
    end
  end
  // ****************************************************************
  // Input synchronisers and edge detection
  // ****************************************************************
  always @(posedge clk)
  begin
    if (reset)
    begin
      // Pins idle high under the reset pull-up, so a low start would fake an edge.
      sync1_reg <= {N{1'b1}};
      sync2_reg <= {N{1'b1}};
      prev_reg <= {N{1'b1}};
    end
    else
    begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end
  // ****************************************************************
  // Interrupt status, set wins over the clearing read
  // ****************************************************************
  always @*
  begin
    irq_stat_next = irq_stat_reg;
    if (rd_stat)
      irq_stat_next = {N{1'b0}};
    irq_stat_next = irq_stat_next | in_edge;
  end
  always @(posedge clk)
  begin
    if (reset)
    begin
      irq_stat_reg <= `TSGPIO_RST_ZERO;
      irq <= 1'b0;
    end
    else
    begin
      irq_stat_reg <= irq_stat_next;
      irq <= |(irq_stat_next & irq_mask_reg);
    end
  end
  // ****************************************************************
  // Timestamp capture on timing pins
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < TS_PINS; i = i + 1)
    begin : g_cap
      // A set edge bit captures on a rising edge, a clear bit on a falling one.
      always @*
      begin
        cap_hit[i] = ts_mode_reg[i] && !dir_reg[i] &&
          (ts_edge_reg[i] ? (sync2_reg[i] && !prev_reg[i]) : (!sync2_reg[i] && prev_reg[i]));
      end
    end
  endgenerate
  always @(posedge clk)
  begin
    if (reset)
    begin
      cap_reg <= {TS_WIDTH{1'b0}};
      ts_capture_pulse <= {TS_PINS{1'b0}};
      ts_capture_value <= {TS_WIDTH{1'b0}};
    end
    else
    begin
      ts_capture_pulse <= cap_hit;
      if (|cap_hit)
      begin
        cap_reg <= timestamp_now;
        ts_capture_value <= timestamp_now;
      end
    end
  end
  // ****************************************************************
  // Pin drive
  // ****************************************************************
  always @(posedge clk)
  begin
    if (reset)
    begin
      pin_out <= {N{1'b0}};
      pin_oe_n <= {N{1'b1}};
      pin_pull_en <= {N{1'b1}};
      pin_pull_up <= {N{1'b1}};
    end
    else
    begin
      pin_out[N-1:TS_PINS] <= out_reg[N-1:TS_PINS];
      pin_out[TS_PINS-1:0] <= (ts_mode_reg & timing_drive) |
        (~ts_mode_reg & out_reg[TS_PINS-1:0]);
      pin_oe_n <= ~dir_reg;
      pin_pull_en <= pull_en_reg & ~dir_reg;
      pin_pull_up <= pull_up_reg;
    end
  end
  // ****************************************************************
  // Register read port
  // ****************************************************************
  always @(posedge clk)
  begin
    if (reset)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `TSGPIO_ADDR_DIR: reg_rdata <= {16'h0000, dir_reg};
        `TSGPIO_ADDR_OUT: reg_rdata <= {16'h0000, out_reg};
        `TSGPIO_ADDR_IN: reg_rdata <= {16'h0000, sync2_reg};
        `TSGPIO_ADDR_PULL_EN: reg_rdata <= {16'h0000, pull_en_reg};
        `TSGPIO_ADDR_PULL_UP: reg_rdata <= {16'h0000, pull_up_reg};
        `TSGPIO_ADDR_IRQ_MASK: reg_rdata <= {16'h0000, irq_mask_reg};
        `TSGPIO_ADDR_IRQ_STAT: reg_rdata <= {16'h0000, irq_stat_reg};
        `TSGPIO_ADDR_TS_MODE: reg_rdata <= {26'h0000000, ts_mode_reg};
        `TSGPIO_ADDR_TS_EDGE: reg_rdata <= {26'h0000000, ts_edge_reg};
        `TSGPIO_ADDR_TS_CAP: reg_rdata <= cap_reg;
        default: reg_rdata <= 32'h00000000;
      endcase
    end
    else
      reg_rdata <= 32'h00000000;
  end
endmodule // tsgpio_port
`default_nettype wire

/* File: bench/tsgpio_props.sv */
// Checker of the pin port's register and pin behaviour.
// Assumes it is bound to tsgpio_port and sees only its ports.
`default_nettype none
module tsgpio_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [15:0] pin_oe_n,
  input wire logic [15:0] pin_pull_en,
  input wire logic [15:0] pin_pull_up,
  input wire logic [5:0] ts_capture_pulse,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_rst; disable iff (1'b0)
    reset |=> pin_oe_n == 16'hffff && pin_pull_up == 16'hffff; endproperty
  a_rst: assert property (p_rst) else $error("pins not back to input pull-up");
  property p_dir;
    reg_wr && reg_addr == 4'h0 |=> ##1 pin_oe_n == ~$past(reg_wdata[15:0], 2); endproperty
  a_dir: assert property (p_dir) else $error("direction not applied");
  property p_pud;
    reg_wr && reg_addr == 4'h4 |=> ##1 pin_pull_up == $past(reg_wdata[15:0], 2); endproperty
  a_pud: assert property (p_pud) else $error("pull select not applied");
  property p_pull; (pin_pull_en & ~pin_oe_n) == 16'h0000; endproperty
  a_pull: assert property (p_pull) else $error("pull on a driven pin");
  property p_idle; !reg_rd |=> reg_rdata == 32'h00000000; endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
  property p_unm; reg_rd && reg_addr > 4'h9 |=> reg_rdata == 32'h00000000; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_lvl; reg_rd && reg_addr == 4'h2 |=> reg_rdata[31:16] == 16'h0000; endproperty
  a_lvl: assert property (p_lvl) else $error("level read upper bits set");
  property p_msk; reg_wr && reg_addr == 4'h5 && reg_wdata[15:0] == 16'h0 |=> ##1 !irq; endproperty
  a_msk: assert property (p_msk) else $error("interrupt with all masked");
  property p_cap; ts_capture_pulse[0] |=> !ts_capture_pulse[0]; endproperty
  a_cap: assert property (p_cap) else $error("capture pulse too long");
endmodule // tsgpio_props
bind tsgpio_port tsgpio_props u_props (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .pin_oe_n, .pin_pull_en, .pin_pull_up, .ts_capture_pulse, .irq);
`default_nettype wire

/* File: bench/tsgpio_board.sv */
// Board model: each pad settles from port drive, then board source, then weak pull.
// Assumes the board drives a pin only where ext_en is set.
`default_nettype none
module tsgpio_board (
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe_n,
  input wire logic [15:0] pin_pull_en,
  input wire logic [15:0] pin_pull_up,
  input wire logic [15:0] ext,
  input wire logic [15:0] ext_en,
  output logic [15:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  assign pin_in = ~pin_oe_n & pin_out | pin_oe_n & (ext_en & ext
    | ~ext_en & (pin_pull_en & pin_pull_up | ~pin_pull_en));
endmodule // tsgpio_board
`default_nettype wire

/* File: bench/tsgpio_port_tb.sv */
// Self-checking bench of the pin port with a board model.
// Assumes the checker is bound from its own file.
`default_nettype none
module tsgpio_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, irq;
  logic [3:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, timestamp_now = 0, ts_capture_value, t;
  logic [31:0] s = 32'h0001831a;
  logic [15:0] pin_in, pin_out, pin_oe_n, pin_pull_en, pin_pull_up, d, o, ext = 0, ext_en = 0;
  logic [5:0] timing_drive = 0, ts_capture_pulse;
  int fail_count = 0, samples_checked = 0, i;
  tsgpio_port DUT (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_in,
    .pin_out, .pin_oe_n, .pin_pull_en, .pin_pull_up, .timing_drive, .timestamp_now,
    .ts_capture_pulse, .ts_capture_value, .irq);
  tsgpio_board u_board (.pin_out, .pin_oe_n, .pin_pull_en, .pin_pull_up, .ext, .ext_en, .pin_in);
  initial forever #20 clk = ~clk;
  function automatic logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [15:0] exp_in(input logic [15:0] dr, ov, ev, en);
    return dr & ov | ~dr & en & ev;
  endfunction
  task automatic chk(input string n, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tmo(input logic f);
    chk("wait", f, 1);
    if (f !== 1'b1)
      test_done();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge clk) reg_wr <= 0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 0;
    #1 t = reg_rdata;
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 0;
    rd(4'h0); chk("dir", t, 0);
    rd(4'h3); chk("pull_en", t, 32'h0000ffff);
    rd(4'h2); chk("level", t, 32'h0000ffff);
    wr(4'h4, 0); tick(4); rd(4'h2); chk("level", t, 0);
    for (int k = 0; k < 6; k++)
    begin
      d = xs(); o = xs(); t = xs();
      @(posedge clk) {ext, ext_en} <= t;
      wr(4'h0, d); wr(4'h1, o); tick(4);
      chk("oe_n", pin_oe_n, {16'h0000, ~d});
      chk("out", pin_out, o);
      chk("pull_en", pin_pull_en, {16'h0000, ~d});
      rd(4'h2); chk("level", t, exp_in(d, o, ext, ext_en));
      chk("irq", irq, 0);
    end
    o = xs();
    wr(4'h7, 32'h3f); wr(4'h0, 32'h3f); @(posedge clk) timing_drive <= o[5:0]; tick(3);
    chk("timing", pin_out[5:0], o[5:0]);
    t = xs();
    wr(4'h0, 0); wr(4'h8, 32'h3f);
    @(posedge clk) {ext, ext_en, timestamp_now} <= {32'h0000ffff, t};
    tick(4); @(posedge clk) ext <= 16'h0001;
    for (i = 0; i < 20 && ts_capture_pulse[0] !== 1'b1; i++) tick(1);
    tmo(ts_capture_pulse[0]); chk("pulse", ts_capture_pulse, 32'h1);
    tick(2); chk("stamp", ts_capture_value, t);
    rd(4'h6); wr(4'h5, 32'h0400); @(posedge clk) ext <= ext ^ 16'h0400;
    for (i = 0; i < 20 && irq !== 1'b1; i++) tick(1);
    tmo(irq); rd(4'h6); chk("status", t, 32'h0400);
    tick(2); chk("irq", irq, 0);
    wr(4'hf, 32'hffffffff); rd(4'hf); chk("unmapped", t, 0);
    wr(4'h0, 32'hffff); @(posedge clk) reset <= 1; @(posedge clk) reset <= 0; tick(2);
    chk("oe_n", pin_oe_n, 32'hffff); chk("pull_up", pin_pull_up, 32'hffff);
    test_done();
  end
endmodule // tsgpio_port_tb
`default_nettype wire
